// >>> mfr_pkg.sv
// mfr_pkg: constants shared by the managed flash card register bank.
// assumes a 250 MHz system clock and a host-driven command line sampled by it.
package mfr_pkg;

  // system clock
  localparam int unsigned CLOCK_PERIOD_NS   = 4;

  // internal power-up routine length
  localparam int unsigned POWERUP_TIME_NS   = 1000;
  localparam logic [15:0] POWERUP_CYCLES    =
    16'((POWERUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // command and response framing on the command line
  localparam logic [7:0]  FRAME_BITS        = 8'h30;
  localparam logic [7:0]  SHORT_RESP_BITS   = 8'h30;
  localparam logic [7:0]  LONG_RESP_BITS    = 8'h88;
  localparam logic [7:0]  RESP_HEADER       = 8'h3F;
  localparam logic [7:0]  SHORT_RESP_TRAIL  = 8'hFF;
  localparam logic [6:0]  CRC7_POLY         = 7'h09;

  // command indices known to the bank; CMD_GO_IDLE is not served
  localparam logic [5:0]  CMD_GO_IDLE       = 6'h00;
  localparam logic [5:0]  CMD_SEND_OP_COND  = 6'h01;
  localparam logic [5:0]  CMD_ALL_SEND_ID   = 6'h02;
  localparam logic [5:0]  CMD_SEND_SPECIFIC = 6'h09;
  localparam logic [5:0]  CMD_PROGRAM_SPEC  = 6'h1B;

  // operating_conditions fields
  localparam logic [1:0]  ACCESS_BYTE       = 2'h0;
  localparam logic [1:0]  ACCESS_SECTOR     = 2'h2;
  localparam logic [8:0]  VWIN_HIGH         = 9'h1FF;
  localparam logic [6:0]  VWIN_MID          = 7'h00;
  localparam logic        VWIN_LOW          = 1'h1;

  // card_identification fields
  localparam logic [1:0]  ID_DEVICE_BGA     = 2'h1;
  localparam logic [7:0]  ID_OEM            = 8'h00;
  localparam logic [6:0]  ID_CHECKSUM       = 7'h00;

  // card_specific_data fields
  localparam logic [1:0]  SD_STRUCTURE      = 2'h3;
  localparam logic [3:0]  SD_SPEC_VERSION   = 4'h4;
  localparam logic [7:0]  SD_ASYNC_ACCESS   = 8'h4F;
  localparam logic [7:0]  SD_CLOCKED_ACCESS = 8'h01;
  localparam logic [7:0]  SD_MAX_FREQ       = 8'h32;
  localparam logic [11:0] SD_CMD_CLASSES    = 12'h0F5;
  localparam logic [3:0]  SD_READ_BL_EXP    = 4'h9;
  localparam logic        SD_PARTIAL_READ   = 1'h0;
  localparam logic [11:0] SD_DEVICE_SIZE    = 12'hFFF;
  localparam logic [2:0]  SD_CURRENT        = 3'h7;
  localparam logic [2:0]  SD_SIZE_MULT      = 3'h7;
  localparam logic [4:0]  SD_ERASE_GRP      = 5'h1F;
  localparam logic [4:0]  SD_ERASE_MULT     = 5'h1F;
  localparam logic        SD_PROTECT_GRP    = 1'h1;
  localparam logic [1:0]  SD_DEFAULT_ECC    = 2'h0;
  localparam logic [2:0]  SD_WRITE_FACTOR   = 3'h2;
  localparam logic [3:0]  SD_WRITE_BL_EXP   = 4'h9;
  localparam logic        SD_PARTIAL_WRITE  = 1'h0;
  localparam logic [6:0]  SD_CHECKSUM       = 7'h00;
  localparam logic [7:0]  SD_WRITABLE_RESET = 8'h00;
  // one-time programmable bits inside the writable byte
  localparam logic [7:0]  SD_OTP_MASK       = 8'h60;

  typedef enum logic [3:0] {
    MFR_IDLE = 4'h1,
    MFR_RECV = 4'h2,
    MFR_WAIT = 4'h4,
    MFR_SEND = 4'h8
  } mfr_state_t;

endpackage

// >>> mfr_sync.sv
// mfr_sync: three-stage input synchroniser with agreement filter and edge pulses.
// assumes inputs asynchronous to clock; one accepted change per agreement of stages two and three.
`timescale 1ns/1ps
`default_nettype none
module mfr_sync #(
  parameter int unsigned     WIDTH      = 1,
  // level of the pin while nobody uses it; keeps reset from faking an edge
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  initial begin
    if (WIDTH < 1) begin
      $error("mfr_sync: WIDTH must be at least 1");
    end
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] up;
    logic [WIDTH-1:0] dn;
  } mfr_sync_t;

  mfr_sync_t r;
  mfr_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // s1 feeds only s2; the filter looks at s2 and s3
    for (int i = 0; i < WIDTH; i++) begin
      next_r.up[i] = 1'b0;
      next_r.dn[i] = 1'b0;
      if ((r.s2[i] == r.s3[i]) && (r.s3[i] != r.lvl[i])) begin
        next_r.lvl[i] = r.s3[i];
        next_r.up[i]  = r.s3[i];
        next_r.dn[i]  = ~r.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r     <= '0;
      r.s1  <= IDLE_LEVEL;
      r.s2  <= IDLE_LEVEL;
      r.s3  <= IDLE_LEVEL;
      r.lvl <= IDLE_LEVEL;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;
  assign rise  = r.up;
  assign fall  = r.dn;

endmodule
`default_nettype wire

// >>> mfr_regs.sv
// mfr_regs: identification and capability registers of a managed flash card,
// served over the card command line.
// assumes the host clock and command line arrive asynchronously and are sampled by CLOCK;
// host clock at least several CLOCK periods wide per phase.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - operating_conditions is 32 bits: voltage window, access mode, power-up flag.
// - power-up flag reads low until the internal power-up routine completes.
// - access-mode field is byte 00b or sector 10b; this device reports sector.
// - voltage bits [23:15] all ones, [14:8] zero, bit 7 one.
// - a 128-bit card_identification register is returned during identification.
// - card_identification [47:16] holds a per-unit random 32-bit serial number.
// - card_specific_data [119:112] async read access time reads 4Fh.
// - card_specific_data [111:104] clocked read access time reads 01h.
// - card_specific_data [103:96] maximum bus clock code reads 32h.
// - card_specific_data [83:80] read block length exponent reads 9h.
// - card_specific_data bit 79 partial reads allowed reads 0.
// - card_specific_data [25:22] write block length exponent reads 9h.
// - card_specific_data bit 21 partial writes allowed reads 0.
// - card_specific_data bit 31 protect group available reads 1.
// - card_specific_data [41:37] erase group multiplier reads 1Fh.
// - erase and program management stay internal; host only reads and writes.
module mfr_regs
  import mfr_pkg::*;
#(
  // arbitrary values, not any real maker's codes
  parameter logic [7:0]  MAKER_ID         = 8'h5A,
  parameter logic [47:0] PRODUCT_NAME     = 48'h4D4652303031,
  parameter logic [7:0]  PRODUCT_REVISION = 8'h10,
  parameter logic [7:0]  MAKE_DATE        = 8'h11,
  parameter logic [31:0] UNIT_SERIAL      = 32'h1234ABCD,
  parameter logic [4:0]  PROTECT_GRP_SIZE = 5'h0F,
  parameter int unsigned RESPONSE_GAP     = 2,
  parameter bit          CHECK_CMD_CRC    = 1'b1
) (
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  input  wire logic MMC_CLK,
  input  wire logic CMD_IN,
  output logic      CMD_OUT,
  output logic      CMD_OE,
  output logic      POWERUP_DONE
);

  initial begin
    if ((RESPONSE_GAP < 1) || (RESPONSE_GAP > 255)) begin
      $error("mfr_regs: RESPONSE_GAP must be 1 to 255");
    end
  end

  localparam logic [7:0] GAP_LAST = 8'(RESPONSE_GAP - 1);

  typedef struct packed {
    mfr_state_t    st;
    logic [7:0]    cnt;
    logic [7:0]    len;
    logic [47:0]   rx;
    logic [135:0]  tx;
    logic [15:0]   pwr_cnt;
    logic          pwr_done;
    logic [7:0]    wr_byte;
    logic          cmd_out;
    logic          cmd_oe;
  } mfr_regs_t;

  mfr_regs_t r;
  mfr_regs_t next_r;

  logic       host_clk_rise;
  logic       host_clk_fall;
  logic       cmd_level;
  logic [47:0] frame;
  logic [5:0]  cmd_index;
  logic        frame_ok;

  mfr_sync #(
    .WIDTH (1)
  ) u_clk_sync (
    .clock    (CLOCK),
    .reset_n  (RESET_N),
    .async_in (MMC_CLK),
    .level    (),
    .rise     (host_clk_rise),
    .fall     (host_clk_fall)
  );

  mfr_sync #(
    .WIDTH      (1),
    .IDLE_LEVEL (1'b1)
  ) u_cmd_sync (
    .clock    (CLOCK),
    .reset_n  (RESET_N),
    .async_in (CMD_IN),
    .level    (cmd_level),
    .rise     (),
    .fall     ()
  );

  function automatic logic [6:0] mfr_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] mfr_op_cond(input logic done);
    return {
      done,
      ACCESS_SECTOR,
      5'h00,
      VWIN_HIGH,
      VWIN_MID,
      VWIN_LOW,
      7'h00
    };
  endfunction

  function automatic logic [127:0] mfr_card_id();
    return {
      MAKER_ID,
      6'h00,
      ID_DEVICE_BGA,
      ID_OEM,
      PRODUCT_NAME,
      PRODUCT_REVISION,
      UNIT_SERIAL,
      MAKE_DATE,
      ID_CHECKSUM,
      1'b1
    };
  endfunction

  function automatic logic [127:0] mfr_card_data(input logic [7:0] wr);
    return {
      SD_STRUCTURE,
      SD_SPEC_VERSION,
      2'h0,
      SD_ASYNC_ACCESS,
      SD_CLOCKED_ACCESS,
      SD_MAX_FREQ,
      SD_CMD_CLASSES,
      SD_READ_BL_EXP,
      SD_PARTIAL_READ,
      3'h0,
      2'h0,
      SD_DEVICE_SIZE,
      SD_CURRENT,
      SD_CURRENT,
      SD_CURRENT,
      SD_CURRENT,
      SD_SIZE_MULT,
      SD_ERASE_GRP,
      SD_ERASE_MULT,
      PROTECT_GRP_SIZE,
      SD_PROTECT_GRP,
      SD_DEFAULT_ECC,
      SD_WRITE_FACTOR,
      SD_WRITE_BL_EXP,
      SD_PARTIAL_WRITE,
      4'h0,
      1'b0,
      wr,
      SD_CHECKSUM,
      1'b1
    };
  endfunction

  assign frame     = {r.rx[46:0], cmd_level};
  assign cmd_index = frame[45:40];
  // start 0, direction 1, end 1, and a good checksum unless checking is off
  assign frame_ok  = !frame[47] && frame[46] && frame[0] &&
                     (!CHECK_CMD_CRC || (mfr_crc7(frame[47:8]) == frame[7:1]));

  always_comb begin
    next_r = r;

    if (!r.pwr_done) begin
      if (r.pwr_cnt >= POWERUP_CYCLES - 16'h0001) begin
        next_r.pwr_done = 1'b1;
      end else begin
        next_r.pwr_cnt = r.pwr_cnt + 16'h0001;
      end
    end

    unique case (r.st)
      MFR_IDLE: begin
        if (host_clk_rise && !cmd_level) begin
          next_r.st  = MFR_RECV;
          next_r.cnt = 8'h01;
          next_r.rx  = 48'h0;
        end
      end
      MFR_RECV: begin
        if (host_clk_rise) begin
          next_r.rx  = frame;
          next_r.cnt = r.cnt + 8'h01;
          if (r.cnt == FRAME_BITS - 8'h01) begin
            next_r.st  = MFR_IDLE;
            next_r.cnt = 8'h00;
            if (frame_ok) begin
              // only register commands are served here
              unique case (cmd_index)
                CMD_SEND_OP_COND: begin
                  next_r.st  = MFR_WAIT;
                  next_r.len = SHORT_RESP_BITS;
                  next_r.tx  = {RESP_HEADER, mfr_op_cond(r.pwr_done), SHORT_RESP_TRAIL, 88'h0};
                end
                CMD_ALL_SEND_ID: begin
                  next_r.st  = MFR_WAIT;
                  next_r.len = LONG_RESP_BITS;
                  next_r.tx  = {RESP_HEADER, mfr_card_id()};
                end
                CMD_SEND_SPECIFIC: begin
                  next_r.st  = MFR_WAIT;
                  next_r.len = LONG_RESP_BITS;
                  next_r.tx  = {RESP_HEADER, mfr_card_data(r.wr_byte)};
                end
                // only writable bits change; otp bits stay set
                CMD_PROGRAM_SPEC: begin
                  next_r.wr_byte = (frame[23:16] & ~SD_OTP_MASK) |
                                   ((frame[23:16] | r.wr_byte) & SD_OTP_MASK);
                end
                default: begin
                  next_r.st = MFR_IDLE;
                end
              endcase
            end
          end
        end
      end
      MFR_WAIT: begin
        if (host_clk_rise) begin
          next_r.cnt = r.cnt + 8'h01;
          if (r.cnt == GAP_LAST) begin
            next_r.st  = MFR_SEND;
            next_r.cnt = 8'h00;
          end
        end
      end
      MFR_SEND: begin
        // drive on falling edges so the host samples stable data on rising edges
        if (host_clk_fall) begin
          if (r.cnt == r.len) begin
            next_r.cmd_oe  = 1'b0;
            next_r.cmd_out = 1'b1;
            next_r.st      = MFR_IDLE;
            next_r.cnt     = 8'h00;
          end else begin
            next_r.cmd_oe  = 1'b1;
            next_r.cmd_out = r.tx[135];
            next_r.tx      = {r.tx[134:0], 1'b0};
            next_r.cnt     = r.cnt + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r          <= '0;
      r.st       <= MFR_IDLE;
      r.wr_byte  <= SD_WRITABLE_RESET;
      r.cmd_out  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign CMD_OUT      = r.cmd_out;
  assign CMD_OE       = r.cmd_oe;
  assign POWERUP_DONE = r.pwr_done;

endmodule
`default_nettype wire

// >>> mfr_monitor.sv
// mfr_monitor: timing and framing checks on the register bank's pins.
// assumes the bench host clock runs at 32 ns, so one response bit spans about 8 CLOCK cycles.
`timescale 1ns/1ps
`default_nettype none
module mfr_monitor (
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  input  wire logic MMC_CLK,
  input  wire logic CMD_IN,
  input  wire logic CMD_OUT,
  input  wire logic CMD_OE,
  input  wire logic POWERUP_DONE
);
  typedef struct packed {
    logic [8:0]  up_cnt;
    logic [10:0] oe_cnt;
  } mfr_mon_t;
  mfr_mon_t mon;
  mfr_mon_t next_mon;

  always_comb begin
    next_mon = mon;
    if (mon.up_cnt != 9'h1FF) next_mon.up_cnt = mon.up_cnt + 9'h001;
    next_mon.oe_cnt = CMD_OE ? mon.oe_cnt + 11'h001 : 11'h000;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) mon <= '0;
    else mon <= next_mon;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // window of a few cycles around 250 absorbs the reset release edge
  property p_busy_early; mon.up_cnt < 9'h0F5 |-> !POWERUP_DONE; endproperty
  a_busy_early: assert property (p_busy_early) else $error("ready flag set too early");
  property p_ready_late; mon.up_cnt >= 9'h0FF |-> POWERUP_DONE; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready flag missing after power-up");
  property p_ready_holds; POWERUP_DONE |=> POWERUP_DONE; endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("ready flag dropped");
  property p_start_low; $rose(CMD_OE) |-> !CMD_OUT; endproperty
  a_start_low: assert property (p_start_low) else $error("response does not open with a low bit");
  property p_idle_high; !CMD_OE |-> CMD_OUT; endproperty
  a_idle_high: assert property (p_idle_high) else $error("command output low while not driving");
  property p_bit_stands; $changed(CMD_OUT) && CMD_OE |=> $stable(CMD_OUT)[*5]; endproperty
  a_bit_stands: assert property (p_bit_stands) else $error("response bit shorter than a host period");
  property p_end_one; $fell(CMD_OE) |-> $past(CMD_OUT); endproperty
  a_end_one: assert property (p_end_one) else $error("last response bit not one");
  property p_host_released; $rose(CMD_OE) |-> $past(CMD_IN); endproperty
  a_host_released: assert property (p_host_released) else $error("drive started on a busy line");
  property p_resp_min; $fell(CMD_OE) |-> mon.oe_cnt >= 11'h172; endproperty
  a_resp_min: assert property (p_resp_min) else $error("response shorter than 48 bits");
  property p_resp_max; mon.oe_cnt <= 11'h44C; endproperty
  a_resp_max: assert property (p_resp_max) else $error("response longer than 136 bits");

  c_answered: cover property ($rose(MMC_CLK) && CMD_OE);
endmodule

bind mfr_regs mfr_monitor mon_u (.CLOCK(CLOCK), .RESET_N(RESET_N), .MMC_CLK(MMC_CLK), .CMD_IN(CMD_IN),
  .CMD_OUT(CMD_OUT), .CMD_OE(CMD_OE), .POWERUP_DONE(POWERUP_DONE));
`default_nettype wire

// >>> mfr_host.sv
// mfr_host: behavioural host controller that sends command frames and gathers responses.
// assumes the bench clock is 4 ns; host clock of 32 ns stands low between transfers.
`timescale 1ns/1ps
`default_nettype none
module mfr_host
  import mfr_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         cmd_line,
  output logic              mmc_clk,
  output logic              cmd_drv,
  output logic              cmd_drv_oe,
  output logic              resp_valid,
  output logic [7:0]        resp_len,
  output logic [135:0]      resp_data
);
  initial begin
    mmc_clk = 1'b0;
    cmd_drv = 1'b1;
    cmd_drv_oe = 1'b0;
    resp_valid = 1'b0;
    resp_len = 8'h00;
    resp_data = '0;
  end

  // sample just before the fall: the device moves its bit a few cycles after each fall
  task automatic tick(output logic smp);
    repeat (4) @(negedge clock);
    mmc_clk = 1'b1;
    repeat (4) @(negedge clock);
    smp = cmd_line;
    mmc_clk = 1'b0;
  endtask

  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic [6:0] crc_err, input int nbits);
    logic [47:0] frame;
    logic [6:0]  crc;
    logic        s;
    int          k;
    crc = 7'h00;
    frame = {2'b01, idx, arg, 7'h00, 1'b1};
    for (int i = 47; i >= 8; i--) crc = {crc[5:0], 1'b0} ^ ((crc[6] ^ frame[i]) ? CRC7_POLY : 7'h00);
    frame[7:1] = crc ^ crc_err;
    cmd_drv_oe = 1'b1;
    for (int i = 47; i >= 0; i--) begin
      cmd_drv = frame[i];
      tick(s);
    end
    cmd_drv_oe = 1'b0;
    cmd_drv = 1'b1;
    resp_data = '0;
    k = 0;
    for (int w = 0; w < 8 && k == 0; w++) begin
      tick(s);
      if (s === 1'b0) k = 1;
    end
    while (k > 0 && k < nbits) begin
      tick(s);
      resp_data = {resp_data[134:0], s};
      k++;
    end
    repeat (2) tick(s);
    resp_len = 8'(k);
    resp_valid = 1'b1;
    @(negedge clock);
    resp_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> mfr_regs_tb.sv
// mfr_regs_tb: reads all three registers, programs the writable byte, feeds refused frames.
// assumes mfr_host as the command line partner and mfr_monitor bound to the design.
`timescale 1ns/1ps
`default_nettype none
module mfr_regs_tb;
  import mfr_pkg::*;
  // arbitrary serial value
  localparam logic [31:0] SERIAL = 32'h5EED0001;
  // indices the bank must ignore
  localparam logic [5:0] BAD_IDX [3] = '{6'h00, 6'h0D, 6'h3F};
  typedef struct packed {
    logic [7:0]   len;
    logic [135:0] data;
  } mfr_note_t;

  logic        clock;
  logic        reset_n;
  logic        mmc_clk;
  logic        cmd_line;
  logic        cmd_out;
  logic        cmd_oe;
  logic        done;
  logic        drv;
  logic        drv_oe;
  logic        rv;
  logic [7:0]  rlen;
  logic [135:0] rdata;
  logic [7:0]  w;
  int          errors;
  int          n_tests;
  mfr_note_t   q[$];

  // line has a pull-up when nobody drives it
  assign cmd_line = cmd_oe ? cmd_out : (drv_oe ? drv : 1'b1);

  mfr_regs #(.UNIT_SERIAL(SERIAL)) dut_u (.CLOCK(clock), .RESET_N(reset_n), .MMC_CLK(mmc_clk),
    .CMD_IN(cmd_line), .CMD_OUT(cmd_out), .CMD_OE(cmd_oe), .POWERUP_DONE(done));
  mfr_host host_u (.clock(clock), .cmd_line(cmd_line), .mmc_clk(mmc_clk), .cmd_drv(drv),
    .cmd_drv_oe(drv_oe), .resp_valid(rv), .resp_len(rlen), .resp_data(rdata));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string name, input logic [143:0] exp, input logic [143:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic run(input logic [5:0] idx, input logic [31:0] arg, input logic [6:0] err, input logic [7:0] len,
                     input logic [135:0] exp);
    q.push_back('{len, exp});
    host_u.xfer(idx, arg, err, (len == 8'h00) ? 48 : int'(len));
  endtask

  function automatic logic [135:0] card_specific_data(input logic [7:0] wb);
    return {2'h0, 6'h3F, 2'h3, 4'h4, 2'h0, 8'h4F, 8'h01, 8'h32, 12'h0F5, 4'h9, 6'h00, 12'hFFF, 15'h7FFF,
            5'h1F, 5'h1F, 5'h0F, 1'h1, 2'h0, 3'h2, 4'h9, 6'h00, wb, 7'h00, 1'h1};
  endfunction

  always @(posedge clock) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) chk("unexpected response", '0, {rlen, rdata});
      else chk("response", q.pop_front(), {rlen, rdata});
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    $display("mismatch watchdog expected finish seen hang");
    test_done();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    void'($urandom(49261));
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    repeat (240) @(negedge clock);
    chk("ready early", 144'h0, {143'h0, done});
    repeat (20) @(negedge clock);
    chk("ready late", 144'h1, {143'h0, done});
    run(CMD_SEND_OP_COND, $urandom(), 7'h00, 8'd48, {88'h0, 8'h3F, 32'hC0FF8080, 8'hFF});
    run(CMD_ALL_SEND_ID, 32'h0, 7'h00, 8'd136,
        {8'h3F, 8'h5A, 6'h00, 2'h1, 8'h00, 48'h4D4652303031, 8'h10, SERIAL, 8'h11, 7'h00, 1'h1});
    run(CMD_SEND_SPECIFIC, $urandom(), 7'h00, 8'd136, card_specific_data(8'h00));
    run(CMD_SEND_OP_COND, $urandom(), 7'(1 << ($urandom() % 7)), 8'h00, '0);
    for (int i = 0; i < 3; i++) run(BAD_IDX[i], $urandom(), 7'h00, 8'h00, '0);
    w = 8'($urandom());
    run(CMD_PROGRAM_SPEC, {16'h0, w, 8'h00}, 7'h00, 8'h00, '0);
    repeat (2) run(CMD_SEND_SPECIFIC, 32'h0, 7'h00, 8'd136, card_specific_data(w));
    // copy and permanent protect bits cannot be cleared once set
    run(CMD_PROGRAM_SPEC, 32'h0, 7'h00, 8'h00, '0);
    run(CMD_SEND_SPECIFIC, 32'h0, 7'h00, 8'd136, card_specific_data(w & 8'h60));
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    chk("ready in reset", 144'h0, {142'h0, done, cmd_oe});
    reset_n = 1'b1;
    repeat (260) @(negedge clock);
    run(CMD_SEND_OP_COND, $urandom(), 7'h00, 8'd48, {88'h0, 8'h3F, 32'hC0FF8080, 8'hFF});
    repeat (4) @(negedge clock);
    chk("notes left", 144'h0, 144'(q.size()));
    test_done();
  end
endmodule
`default_nettype wire
